// file: dv/port_six_pins_model.sv
// Outside world of the port six pins: other drivers and floating lines
`timescale 1ns/1ps
module port_six_pins_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] float_reg = 8'h5a; // Level of a pin nobody drives
  // Undriven pins wander each cycle so a stale level never passes as real
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  // The device driver wins; otherwise the outside driver, else the float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : float_reg[i]);
    end
  end
endmodule : port_six_pins_model

// file: dv/port_six_props.sv
// Property checker for the port six pins and register reads
`timescale 1ns/1ps
module port_six_props
  import port_six_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic hw_standby,
  input wire logic sys_clock_phase,
  input wire logic bus_grant_ack_n,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic bus_request_in_n,
  input wire logic wait_in_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Any setup cycle, and a read setup of one address
  sequence setup_s; psel && !penable; endsequence
  sequence rd_s(a); setup_s and !pwrite && paddr == a; endsequence
  // Zero wait states: answer in the access cycle, gone after it
  AST_ANSWER: assert property (setup_s |=> pready ##1 !pready)
    else $error("bus answer not in first access cycle");
  AST_DIR_ONES: assert property (rd_s(PORT_SIX_DIRECTION_ADDR) |=> prdata == 32'hff)
    else $error("direction read not all ones");
  // Bit 7 may only read low when the pin itself was low
  AST_DATA_BIT7: assert property (rd_s(PORT_SIX_OUTPUT_DATA_ADDR) |=> prdata[7] || !$past(pin_in[7]))
    else $error("data bit 7 read wrong");
  AST_PIN7_CLK: assert property (pin_oe[PIN_SEVEN] |-> pin_out[PIN_SEVEN] == $past(sys_clock_phase))
    else $error("pin 7 not showing clock");
  AST_STORE_NO_PIN: assert property (pin_oe[6:3] == 4'h0)
    else $error("storage bits drive a pin");
  AST_HWSB_OFF: assert property ($past(hw_standby) |-> pin_oe == 8'h00)
    else $error("driver on in hardware standby");
  AST_REQ_IN: assert property (!bus_request_in_n |-> !$past(pin_in[PIN_REQUEST]))
    else $error("request does not follow pin 1");
  // Release owns pins 2 and 1: acknowledge out, request in
  AST_ACK_OUT: assert property (!bus_request_in_n && !$past(hw_standby) |->
    pin_oe[2:1] == 2'b10 && pin_out[PIN_ACK] == $past(bus_grant_ack_n))
    else $error("acknowledge pin wrong under release");
  AST_WAIT_IN: assert property (!wait_in_n |-> !$past(pin_in[PIN_WAIT]) && !pin_oe[PIN_WAIT])
    else $error("wait pin wrong");
endmodule : port_six_props

bind port_six_gpio_mux port_six_props u_port_six_props (.*);

// file: dv/tb_top.sv
// Self-checking bench for the port six block
`timescale 1ns/1ps
`define CHK(nm, x, s) begin checked++; if ((s) !== (x)) begin miscompares++; $display("ERROR %s expected %h seen %h", nm, x, s); end end
module tb_top;
  import port_six_pkg::*;
  localparam logic [ADDR_W-1:0] DIR = PORT_SIX_DIRECTION_ADDR; // Short aliases
  localparam logic [ADDR_W-1:0] DAT = PORT_SIX_OUTPUT_DATA_ADDR;
  localparam logic [ADDR_W-1:0] CTL = PIN_FUNCTION_CONTROL_ADDR;
  logic clk, rst_b, ce, psel, penable, pwrite, hw_standby, bus_grant_ack_n;
  logic sys_clock_phase = 1'b0; // Clock phase offered to pin 7, one driver only
  logic pready, pslverr, bus_request_in_n, wait_in_n, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [7:0] pin_in, pin_out, pin_oe, ext_val, ext_en;
  int miscompares = 0;
  int checked = 0;
  port_six_gpio_mux u_port_six_gpio_mux (.*);
  port_six_pins_model u_port_six_pins_model (.*);
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Clock phase offered to pin 7
  always @(posedge clk) sys_clock_phase <= ~sys_clock_phase;
  // One bus transfer; waits for pready without assuming a latency
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Look at pready at each rising edge; the answer is taken at that edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk_rd(input logic [ADDR_W-1:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00, 4'hf);
    `CHK("read", {24'h0, x}, q)
  endtask : chk_rd
  // Pins follow a register change one cycle after the write lands
  task settle;
    repeat (2) @(negedge clk);
  endtask : settle
  task t_reset;
    chk_rd(DIR, 8'hff);
    chk_rd(DAT, 8'h85);
    settle;
    `CHK("oe", 8'h80, pin_oe)
    $display("test reset done");
  endtask : t_reset
  task t_gpio;
    apb(1'b1, DIR, 8'h7f, 4'hf);
    // Outputs enabled, so the read shows the reset contents of the data register
    chk_rd(DAT, 8'h80);
    apb(1'b1, DAT, 8'h55, 4'hf);
    settle;
    `CHK("oe", 8'h87, pin_oe)
    `CHK("out", 3'b101, pin_out[2:0])
    // Outside driver levels differ from the stored bits so the two read sources are told apart once the pins are inputs
    @(posedge clk);
    ext_val <= 8'h06;
    chk_rd(DAT, 8'hd5);
    apb(1'b1, DAT, 8'h00, 4'h0);
    chk_rd(DAT, 8'hd5);
    apb(1'b1, DAT, 8'h2a, 4'hf);
    chk_rd(DAT, 8'haa);
    apb(1'b1, DIR, 8'h00, 4'hf);
    chk_rd(DIR, 8'hff);
    chk_rd(DAT, 8'h86);
    settle;
    `CHK("oe", 8'h80, pin_oe)
    $display("test gpio done");
  endtask : t_gpio
  task t_func;
    @(posedge clk);
    ext_val <= 8'h00;
    bus_grant_ack_n <= 1'b0;
    apb(1'b1, CTL, 8'h01, 4'hf);
    settle;
    `CHK("oe7", 1'b0, pin_oe[7])
    chk_rd(DAT, 8'h00);
    ext_val <= 8'h80;
    chk_rd(DAT, 8'h80);
    // Pin 0 direction stays low before wait is enabled
    apb(1'b1, DIR, 8'h06, 4'hf);
    apb(1'b1, CTL, 8'h02, 4'hf);
    settle;
    `CHK("rel", 4'b1100, {pin_oe[7], pin_oe[2:1], pin_out[2]})
    // Request trails the pin by a cycle, and pin 1 was still driven a cycle ago
    @(negedge clk);
    `CHK("req", 1'b0, bus_request_in_n)
    apb(1'b1, CTL, 8'h04, 4'hf);
    settle;
    `CHK("wait", 2'b00, {pin_oe[0], wait_in_n})
    `CHK("gp", 2'b11, pin_oe[2:1])
    apb(1'b1, CTL, 8'h00, 4'hf);
    $display("test functions done");
  endtask : t_func
  task t_err;
    apb(1'b0, 24'h000004, 8'h00, 4'hf);
    `CHK("err", 33'h1_0000_0000, {e, q})
    $display("test unmapped done");
  endtask : t_err
  task t_hwsb;
    apb(1'b1, DIR, 8'h07, 4'hf);
    ext_val <= 8'h03;
    @(posedge clk);
    hw_standby <= 1'b1;
    settle;
    settle;
    `CHK("sb_oe", 8'h00, pin_oe)
    @(posedge clk);
    hw_standby <= 1'b0;
    chk_rd(DAT, 8'h83);
    settle;
    `CHK("sb_rel", 8'h80, pin_oe)
    // Standby must also have cleared the stored data bits
    apb(1'b1, DIR, 8'h7f, 4'hf);
    chk_rd(DAT, 8'h80);
    $display("test standby done");
  endtask : t_hwsb
  // Reset in mid-run: drivers drop at once, direction returns to inputs
  task t_rerst;
    @(posedge clk);
    rst_b <= 1'b0;
    @(negedge clk);
    `CHK("rst_oe", 8'h00, pin_oe)
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk_rd(DAT, 8'h83);
    $display("test mid reset done");
  endtask : t_rerst
  task wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence: reset, then every scenario
  initial begin
    {rst_b, psel, penable, pwrite, hw_standby} = 5'h00;
    {paddr, pwdata, pstrb} = '0;
    {ce, bus_grant_ack_n, ext_en, ext_val} = {2'b11, 8'hff, 8'h05};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_gpio;
    t_func;
    t_err;
    t_hwsb;
    t_rerst;
    wrap_up;
  end
  // Watchdog far beyond the hundred-odd cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule : tb_top

// file: pkg/port_six_mux_if.sv
// Carrier between the register core and the pin function multiplexer
`timescale 1ns/1ps
interface port_six_mux_if;
  logic [7:0] direction; // Direction register contents
  logic [7:0] output_data; // Data register contents
  logic [7:0] pin_level; // Sampled pin levels
  logic clock_output_stop; // Pin 7 is an input when high
  logic bus_release_enable; // Pins 2 and 1 belong to bus release
  logic wait_pin_enable; // Pin 0 belongs to the wait function
  logic sys_clock; // Clock phase to show on pin 7
  logic bus_grant_ack_n; // Acknowledge level to drive on pin 2
  logic hw_standby; // Hardware standby turns all drivers off
  logic [7:0] out_next; // Pin drive values
  logic [7:0] oe_next; // Pin drive enables
  logic [7:0] read_value; // Data register read image
  logic request_next; // Bus request level toward the controller
  logic wait_next; // Wait level toward the controller
  // Register side
  modport core (
    output direction, output_data, pin_level, clock_output_stop, bus_release_enable, wait_pin_enable,
    output sys_clock, bus_grant_ack_n, hw_standby,
    input out_next, oe_next, read_value, request_next, wait_next
  );
  // Multiplexer side
  modport mux (
    input direction, output_data, pin_level, clock_output_stop, bus_release_enable, wait_pin_enable,
    input sys_clock, bus_grant_ack_n, hw_standby,
    output out_next, oe_next, read_value, request_next, wait_next
  );
endinterface : port_six_mux_if

// file: pkg/port_six_pkg.sv
// Constants, field positions and reset values shared by the port six files
// Operation
// - Eight-bit write-only direction register, one bit per pin
// - Direction bits 7-3 reserved; bit 7 fixed one
// - Direction register always reads back all ones
// - General pins 2-0: direction one drives, zero inputs
// - Reset, hardware standby load direction with 80
// - Software standby keeps general outputs driving
// - Pin 7 outputs clock unless clock stop set
// - Data register value drives general output pins 2-0; pin 7 drives the clock
// - Data bit 7 unwritable; reads one or pin
// - Data bits 6-3 storage; read depends on direction
// - Data bits 2-0 read pin or stored value
// - Reset, hardware standby load data with 80
// - Bus release makes pins 2,1 acknowledge, request
// - Wait enable makes pin 0 the wait input
package port_six_pkg;
  // Register bus address width, wide enough for index times four
  localparam int ADDR_W = 24;
  // Printed offsets are register indices; byte address is four times that
  localparam logic [ADDR_W-1:0] PORT_SIX_DIRECTION_INDEX = 24'h0ee005;
  localparam logic [ADDR_W-1:0] PORT_SIX_OUTPUT_DATA_INDEX = 24'h0fffd5;
  localparam logic [ADDR_W-1:0] PIN_FUNCTION_CONTROL_INDEX = 24'h0ee010;
  localparam logic [ADDR_W-1:0] PORT_SIX_DIRECTION_ADDR = {PORT_SIX_DIRECTION_INDEX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] PORT_SIX_OUTPUT_DATA_ADDR = {PORT_SIX_OUTPUT_DATA_INDEX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] PIN_FUNCTION_CONTROL_ADDR = {PIN_FUNCTION_CONTROL_INDEX[ADDR_W-3:0], 2'b00};
  // Reset values
  localparam logic [7:0] DIRECTION_RESET = 8'h80;
  localparam logic [7:0] OUTPUT_DATA_RESET = 8'h80;
  localparam logic [2:0] CONTROL_RESET = 3'h0;
  // Fixed and read-back patterns
  localparam logic [7:0] DIRECTION_FIXED_MASK = 8'h80;
  localparam logic [7:0] DIRECTION_READ_VALUE = 8'hff;
  localparam logic [7:0] DATA_WRITE_MASK = 8'h7f;
  localparam logic UNDEFINED_READ_BIT = 1'b0;
  // Pin positions
  localparam int PIN_SEVEN = 7;
  localparam int PIN_ACK = 2;
  localparam int PIN_REQUEST = 1;
  localparam int PIN_WAIT = 0;
  localparam int STORAGE_LO = 3;
  localparam int STORAGE_HI = 6;
  // Pin function control register fields
  localparam int CTL_CLOCK_OUTPUT_STOP = 0;
  localparam int CTL_BUS_RELEASE_ENABLE = 1;
  localparam int CTL_WAIT_PIN_ENABLE = 2;
endpackage : port_six_pkg

// file: rtl/port_six_gpio_mux.sv
// Port six general I/O block with APB register access and shared pin functions
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module port_six_gpio_mux #(
  parameter int PORT_W = 8 // Port width; the pin map is fixed at eight
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [port_six_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_standby,
  input wire logic sys_clock_phase,
  input wire logic bus_grant_ack_n,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic bus_request_in_n,
  output logic wait_in_n
);
  import port_six_pkg::*;

  // The pin map below is written for exactly eight bits
  if (PORT_W != 8) begin : g_width_check
    $error("port_six_gpio_mux supports only PORT_W of 8");
  end

  // All block state except the two reset release flops in one record
  typedef struct packed {
    logic [7:0] direction; // Direction register
    logic [7:0] output_data; // Data register
    logic [2:0] control; // Pin function control bits
    logic [7:0] pin_out; // Registered pin drive values
    logic [7:0] pin_oe; // Registered pin drive enables
    logic bus_request; // Registered request toward the controller
    logic wait_req; // Registered wait toward the controller
    logic [31:0] prdata; // Read data held for the access phase
    logic pready; // Access phase ready
    logic pslverr; // Access phase error
  } core_s;

  // Two-stage reset release
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  // Registered state and its next value
  core_s state_reg;
  core_s state_next;
  // Decode helpers
  logic setup_phase;
  logic access_done;
  logic hit_direction;
  logic hit_data;
  logic hit_control;
  logic hit_any;
  logic lane0_write;

  // Link to the pin multiplexer
  port_six_mux_if mux_bus ();

  // Reset release: assert at once, release after two clean edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else if (ce) begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  // Feed the multiplexer from stored registers and the sampled pins
  assign mux_bus.direction = state_reg.direction;
  assign mux_bus.output_data = state_reg.output_data;
  assign mux_bus.pin_level = pin_in;
  assign mux_bus.clock_output_stop = state_reg.control[CTL_CLOCK_OUTPUT_STOP];
  assign mux_bus.bus_release_enable = state_reg.control[CTL_BUS_RELEASE_ENABLE];
  assign mux_bus.wait_pin_enable = state_reg.control[CTL_WAIT_PIN_ENABLE];
  assign mux_bus.sys_clock = sys_clock_phase;
  assign mux_bus.bus_grant_ack_n = bus_grant_ack_n;
  assign mux_bus.hw_standby = hw_standby;

  // Pin function selection and read image
  port_six_pin_mux u_pin_mux (
    .m (mux_bus.mux)
  );

  // Address decode over the full byte address; low two bits must be zero
  always_comb begin
    hit_direction = (paddr == PORT_SIX_DIRECTION_ADDR);
    hit_data = (paddr == PORT_SIX_OUTPUT_DATA_ADDR);
    hit_control = (paddr == PIN_FUNCTION_CONTROL_ADDR);
    hit_any = hit_direction | hit_data | hit_control;
    // Only the low byte lane carries register data
    lane0_write = pwrite & pstrb[0];
  end

  // Bus phases: ready is raised at the edge ending the setup cycle for a zero-wait access
  always_comb begin
    setup_phase = psel & ~penable;
    access_done = psel & penable & state_reg.pready;
  end

  // Next state of the whole block
  always_comb begin
    state_next = state_reg;

    // Answer: ready stands for exactly the first access cycle
    state_next.pready = setup_phase;
    if (setup_phase) begin
      // Unmapped addresses answer with an error and zero data
      state_next.pslverr = ~hit_any;
      state_next.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_direction) begin
          // Write-only register gives no view of its contents
          state_next.prdata = {24'h00_0000, DIRECTION_READ_VALUE};
        end else if (hit_data) begin
          // Mixed image: pins, stored bits or fixed values per bit
          state_next.prdata = {24'h00_0000, mux_bus.read_value};
        end else if (hit_control) begin
          state_next.prdata = {29'h0000_0000, state_reg.control};
        end
      end
    end else if (access_done) begin
      // Hold nothing past the access
      state_next.pslverr = 1'b0;
      state_next.prdata = 32'h0000_0000;
    end

    // Writes land only at the completing access edge
    if (access_done && lane0_write) begin
      if (hit_direction) begin
        // Bit 7 stays one whatever is written; 6-3 are kept as storage
        state_next.direction = pwdata[7:0] | DIRECTION_FIXED_MASK;
      end
      if (hit_data) begin
        // Bit 7 cannot be written and keeps its reset one
        state_next.output_data = (pwdata[7:0] & DATA_WRITE_MASK) | (state_reg.output_data & ~DATA_WRITE_MASK);
      end
      if (hit_control) begin
        state_next.control = pwdata[2:0];
      end
    end

    // Hardware standby reinitialises the registers like a reset
    if (hw_standby) begin
      state_next.direction = DIRECTION_RESET;
      state_next.output_data = OUTPUT_DATA_RESET;
      state_next.control = CONTROL_RESET;
    end

    // Pins follow the multiplexer; nothing here depends on software
    // standby, so enabled outputs keep their levels through it
    state_next.pin_out = mux_bus.out_next;
    state_next.pin_oe = mux_bus.oe_next;
    state_next.bus_request = mux_bus.request_next;
    state_next.wait_req = mux_bus.wait_next;
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge clk or negedge rst_sync2_reg) begin
    if (!rst_sync2_reg) begin
      state_reg.direction <= DIRECTION_RESET;
      state_reg.output_data <= OUTPUT_DATA_RESET;
      state_reg.control <= CONTROL_RESET;
      state_reg.pin_out <= 8'h00;
      state_reg.pin_oe <= 8'h00;
      state_reg.bus_request <= 1'b1;
      state_reg.wait_req <= 1'b1;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign pin_out = state_reg.pin_out;
  assign pin_oe = state_reg.pin_oe;
  assign bus_request_in_n = state_reg.bus_request;
  assign wait_in_n = state_reg.wait_req;
endmodule : port_six_gpio_mux

// file: rtl/port_six_pin_mux.sv
// Pin function selection and data register read image for port six
`timescale 1ns/1ps
module port_six_pin_mux (
  port_six_mux_if.mux m
);
  import port_six_pkg::*;

  // Per-bit general image before alternate functions are laid over it
  logic [7:0] gen_oe;
  logic [7:0] gen_read;

  // One general I/O slice per pin bit
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      if (b == PIN_SEVEN) begin : g_clk
        // Unwritable bit: one while the clock is out, pin level otherwise
        assign gen_read[b] = m.clock_output_stop ? m.pin_level[b] : 1'b1;
        assign gen_oe[b] = 1'b0;
      end else if (b >= STORAGE_LO) begin : g_store
        // Storage only, never reaches a pin
        assign gen_read[b] = m.direction[b] ? m.output_data[b] : UNDEFINED_READ_BIT;
        assign gen_oe[b] = 1'b0;
      end else begin : g_gpio
        // Real pin: stored value when output, pin level when input
        assign gen_read[b] = m.direction[b] ? m.output_data[b] : m.pin_level[b];
        assign gen_oe[b] = m.direction[b];
      end
    end
  endgenerate

  assign m.read_value = gen_read;

  // Drive values and enables, alternate functions take priority
  always_comb begin
    m.out_next = 8'h00;
    m.oe_next = 8'h00;
    // General pins drive the stored data where enabled
    m.out_next[PIN_ACK] = m.output_data[PIN_ACK];
    m.out_next[PIN_REQUEST] = m.output_data[PIN_REQUEST];
    m.out_next[PIN_WAIT] = m.output_data[PIN_WAIT];
    m.oe_next[PIN_ACK] = gen_oe[PIN_ACK];
    m.oe_next[PIN_REQUEST] = gen_oe[PIN_REQUEST];
    m.oe_next[PIN_WAIT] = gen_oe[PIN_WAIT];
    // Clock output unless stopped
    if (!m.clock_output_stop) begin
      m.out_next[PIN_SEVEN] = m.sys_clock;
      m.oe_next[PIN_SEVEN] = 1'b1;
    end
    // Bus release: pin 2 acknowledge out, pin 1 request in
    if (m.bus_release_enable) begin
      m.out_next[PIN_ACK] = m.bus_grant_ack_n;
      m.oe_next[PIN_ACK] = 1'b1;
      m.out_next[PIN_REQUEST] = 1'b0;
      m.oe_next[PIN_REQUEST] = 1'b0;
    end
    // Wait input owns pin 0; a stray direction bit cannot fight it
    if (m.wait_pin_enable) begin
      m.out_next[PIN_WAIT] = 1'b0;
      m.oe_next[PIN_WAIT] = 1'b0;
    end
    // Hardware standby floats every driver
    if (m.hw_standby) begin
      m.oe_next = 8'h00;
    end
  end

  // Alternate inputs, inactive high when their function is off
  always_comb begin
    m.request_next = m.bus_release_enable ? m.pin_level[PIN_REQUEST] : 1'b1;
    m.wait_next = m.wait_pin_enable ? m.pin_level[PIN_WAIT] : 1'b1;
  end
endmodule : port_six_pin_mux
